/* dv/tb_usb_endpoint_buffer_control.sv */
// Self-checking bench for the endpoint buffer control block
`timescale 1ns/1ps
`include "ueb_consts.svh"
module tb_usb_endpoint_buffer_control import ueb_pkg::*; ;
  localparam logic [2:0] hs_ack = {1'b1, UEB_HS_ACK};
  localparam logic [2:0] hs_nak = {1'b1, UEB_HS_NAK};
  logic clk, nrst, ext_n, bus_rst, pdn, avail, conn;
  ueb_cpu_req_t cpu;
  ueb_sie_t serial_interface_engine;
  ueb_hs_t hs;
  logic [7:0] rdata, txd;
  logic [6:0] txl;
  logic [2:0] tog;
  int errors = 0;
  int num_checks = 0;
  ueb_ctrl dut (.ref_clk_i(clk), .nrst_i(nrst), .external_reset_pin_n_i(ext_n),
    .usb_bus_reset_i(bus_rst), .power_down_i(pdn), .cpu_i(cpu), .cpu_rdata_o(rdata),
    .sie_i(serial_interface_engine), .hs_o(hs), .tx_data_o(txd), .tx_len_o(txl), .data_toggle_o(tog),
    .bulk_out_data_avail_o(avail), .connect_o(conn));
  ueb_host_model host (.ref_clk_i(clk), .hs_i(hs), .sie_o(serial_interface_engine));
  // Byte comparison with counting
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Register port: command byte, then n data bytes; reads compare d, d+1, ...
  task automatic acc(input logic w, input logic [4:0] a, input int n, input logic [7:0] d);
    @(posedge clk) cpu <= '{1'b1, w, a, 1'b0, 8'h00};
    for (int i = 0; i < n; i++) begin
      @(posedge clk) cpu <= '{1'b0, w, a, 1'b1, d + i[7:0]};
      @(posedge clk) cpu <= '0;
      @(posedge clk) if (!w) chk("read byte", rdata, d + i[7:0]);
    end
  endtask
  task automatic hs_chk(input logic i, input logic [1:0] ep, input int n, input logic bad,
                        input logic [2:0] e);
    ueb_hs_t h;
    host.xfer(i, ep, n, bad, h);
    chk("handshake", {5'h00, h}, {5'h00, e});
  endtask
  task automatic t_ep0;
    acc(1'b1, `UEB_R_TOGDIS, 1, 8'h20);
    hs_chk(1'b0, 2'h1, 2, 1'b0, 3'h0);
    chk("avail", {7'h00, avail}, 8'h00);
    hs_chk(1'b0, 2'h0, 4, 1'b1, 3'h0);
    acc(1'b0, `UEB_R_EPIRQ, 1, 8'h00);
    hs_chk(1'b0, 2'h0, 4, 1'b0, hs_ack);
    acc(1'b0, `UEB_R_CTRL_EP_BYTE_COUNT, 1, 8'h04);
    acc(1'b0, `UEB_R_EPIRQ, 1, 8'h02);
    acc(1'b0, `UEB_R_EP0BUF, 4, 8'h40);
    @(posedge clk) pdn <= 1'b1;
    acc(1'b0, `UEB_R_CTRL_EP_BYTE_COUNT, 1, 8'h00);
    @(posedge clk) pdn <= 1'b0;
    hs_chk(1'b1, 2'h0, 0, 1'b0, hs_nak);
    acc(1'b0, `UEB_R_PIN_CONTROL_REG, 1, 8'h20);
    acc(1'b1, `UEB_R_PIN_CONTROL_REG, 1, 8'h20);
    acc(1'b0, `UEB_R_PIN_CONTROL_REG, 1, 8'h00);
    acc(1'b1, `UEB_R_EP0BUF, 3, 8'hC0);
    acc(1'b1, `UEB_R_CTRL_EP_BYTE_COUNT, 1, 8'h83);
    acc(1'b0, `UEB_R_CTRL_EP_BYTE_COUNT, 1, 8'h03);
    chk("tx length", {1'b0, txl}, 8'h03);
    hs_chk(1'b1, 2'h0, 0, 1'b0, {1'b1, UEB_HS_DATA});
    chk("tx byte", txd, 8'h40);
    acc(1'b1, `UEB_R_TOGDIS, 1, 8'h00);
  endtask
  task automatic t_bulk;
    hs_chk(1'b0, 2'h1, 3, 1'b0, hs_ack);
    chk("avail", {7'h00, avail}, 8'h01);
    hs_chk(1'b0, 2'h1, 5, 1'b0, hs_ack);
    hs_chk(1'b0, 2'h1, 2, 1'b0, hs_nak);
    acc(1'b0, `UEB_R_EP1BC, 1, 8'h03);
    acc(1'b0, `UEB_R_EP1BUF, 3, 8'h30);
    acc(1'b1, `UEB_R_EPIRQ, 1, 8'h04);
    chk("avail", {7'h00, avail}, 8'h01);
    acc(1'b0, `UEB_R_EP1BC, 1, 8'h05);
    acc(1'b0, `UEB_R_EP1BUF, 5, 8'h50);
    acc(1'b1, `UEB_R_EPIRQ, 1, 8'h04);
    chk("avail", {7'h00, avail}, 8'h00);
  endtask
  task automatic t_tog;
    logic [2:0] m;
    hs_chk(1'b0, 2'h1, 1, 1'b0, hs_ack);
    hs_chk(1'b1, 2'h2, 0, 1'b0, 3'h0);
    hs_chk(1'b1, 2'h3, 0, 1'b0, 3'h0);
    chk("toggle", {5'h00, tog}, 8'h07);
    for (int b = 0; b < 3; b++) begin
      m = 3'b110 << b;
      acc(1'b1, `UEB_R_TOGDIS, 1, 8'h04 << b);
      @(posedge clk);
      chk("toggle", {5'h00, tog}, {5'h00, m});
      acc(1'b0, `UEB_R_TOGDIS, 1, 8'h00);
    end
  endtask
  task automatic t_rst;
    acc(1'b1, `UEB_R_USBCTL, 1, 8'h08);
    hs_chk(1'b0, 2'h1, 2, 1'b0, hs_ack);
    @(posedge clk) bus_rst <= 1'b1;
    @(posedge clk) bus_rst <= 1'b0;
    @(posedge clk);
    chk("toggle", {5'h00, tog}, 8'h00);
    hs_chk(1'b0, 2'h1, 2, 1'b0, hs_ack);
    @(posedge clk) ext_n <= 1'b0;
    repeat (3) @(posedge clk);
    ext_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("connect", {7'h00, conn}, 8'h01);
    chk("toggle", {5'h00, tog}, 8'h00);
    chk("avail", {7'h00, avail}, 8'h00);
    acc(1'b0, `UEB_R_EP1BC, 1, 8'h00);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    @(posedge clk);
    chk("connect", {7'h00, conn}, 8'h00);
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  // Main sequence
  initial begin
    {nrst, ext_n, bus_rst, pdn} = 4'b0100;
    cpu = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_ep0();
    t_bulk();
    t_tog();
    t_rst();
    final_report;
  end
endmodule

/* dv/ueb_host_model.sv */
// Behavioural USB host that drives token, data and end events
`timescale 1ns/1ps
module ueb_host_model import ueb_pkg::*; (
  input wire logic ref_clk_i, // Device clock
  input wire ueb_hs_t hs_i, // Handshake from device
  output ueb_sie_t sie_o // Packet events to device
);
  // Quiet bus at start
  initial sie_o = '0;
  // Token, n bytes, end event, then four cycles watching for the handshake
  task automatic xfer(input logic is_in, input logic [1:0] ep, input int n, input logic bad,
                      output ueb_hs_t h);
    ueb_sie_t s;
    h = '0;
    s = '0;
    s.tok_in = is_in;
    s.tok_out = !is_in;
    s.ep = ep;
    @(posedge ref_clk_i) sie_o <= s;
    for (int i = 0; i < n; i++) begin
      s = '0;
      s.rx_stb = 1'b1;
      s.rx_data = {n[3:0], i[3:0]};
      @(posedge ref_clk_i) sie_o <= s;
    end
    s = '0;
    s.ep = ep;
    s.rx_data = ~sie_o.rx_data; // Released data line shows no stale byte
    s.pkt_ok = !is_in && !bad;
    s.pkt_err = !is_in && bad; // Corrupted packet, host retries later
    s.host_ack = is_in && ep[1];
    @(posedge ref_clk_i) sie_o <= s;
    for (int j = 0; j < 4; j++) begin
      @(posedge ref_clk_i);
      if (hs_i.valid) h = hs_i;
      s = '0;
      s.ep = ep;
      s.rx_data = ~sie_o.rx_data;
      s.host_ack = hs_i.valid && hs_i.code == UEB_HS_DATA; // Host acks received data
      s.tx_stb = s.host_ack; // Pull one IN byte with the ack
      sie_o <= s;
    end
  endtask
endmodule

/* hw/ueb_consts.svh */
// Register addresses, field positions and sizes for the endpoint buffer block
`ifndef UEB_CONSTS_SVH
`define UEB_CONSTS_SVH
`define UEB_R_EP0BUF 5'h00
`define UEB_R_EP1BUF 5'h01
`define UEB_R_CTRL_EP_BYTE_COUNT 5'h05
`define UEB_R_EP1BC 5'h06
`define UEB_R_TOGDIS 5'h0A
`define UEB_R_EPIRQ 5'h0B
`define UEB_R_USBCTL 5'h0F
`define UEB_R_PIN_CONTROL_REG 5'h11
`define UEB_R_FIRST_CTL 5'h05
`define UEB_R_LAST 5'h14
`define UEB_B_CTG_LO 2
`define UEB_B_CTG_HI 4
`define UEB_B_DIS1 5
`define UEB_B_IRQ_OUT0 1
`define UEB_B_IRQ_OUT1 2
`define UEB_B_CONNECT 3
`define UEB_B_CHIPRES 5
`define UEB_B_NAK0 5
`define UEB_BUF_BYTES 7'h40
`define UEB_PTR_STEP 7'h01
`define UEB_EP_CTRL 2'h0
`define UEB_EP_BULK 2'h1
`define UEB_EP_IN2 2'h2
`define UEB_EP_IN3 2'h3
`define UEB_BYTE_ZERO 8'h00
`endif

/* hw/ueb_ctrl.sv */
// Endpoint buffers, byte counts and data toggles behind the register port
`timescale 1ns/1ps
`include "ueb_consts.svh"
// Operation
// (RULE1) Attach pull-up bit cleared only by power-on reset, kept over chip reset.
// (RULE2) Writing one to bit 2 sets endpoint 1 OUT toggle to DATA0; self-clears.
// (RULE3) Writing one to bit 3 sets endpoint 2 IN toggle to DATA0; self-clears.
// (RULE4) Writing one to bit 4 sets endpoint 3 IN toggle to DATA0; self-clears.
// (RULE5) Chip reset or USB bus reset returns every toggle to DATA0.
// (RULE6) Firmware clears toggles on Set_Configuration or halt Clear_Feature.
// (RULE7) Byte count write after filling arms endpoint 0 IN for data.
// (RULE8) Good endpoint 0 OUT: ACK, load count, set data-available flag.
// (RULE9) Byte counts use bits 6..0; bit 7 ignores writes, reads zero.
// (RULE10) Endpoint 0 has one 64-byte buffer shared by IN and OUT.
// (RULE11) CPU loads whole 0..64 byte packet before writing the count.
// (RULE12) Faulty packets change no flag, count or register; host retries.
// (RULE13) Endpoint 0 IN NAK sets flag bit 5; write one clears it.
// (RULE14) Endpoint 1 OUT disable bit makes engine ignore that endpoint.
// (RULE15) Endpoint 0 can never be disabled.
// (RULE16) Good endpoint 1 OUT: ACK, store count, raise data-available.
// (RULE17) Endpoint 1 OUT has two 64-byte buffers with own counts.
// (RULE18) First packet into empty banks lifts the single data-available flag.
// (RULE19) One bank busy: second OUT packet goes to free bank, ACKed.
// (RULE20) Both banks busy: further OUT packet gets NAK, nothing stored.
// (RULE21) CPU reads endpoint 1 count, then exactly that many bytes.
// (RULE22) Buffers zeroed by power-on and chip reset; power-down blocks access.
// (RULE23) Buffer ports keep their address; control registers auto-increment.
// (RULE24) Toggle-clear bit reads zero within a cycle of the toggle reset.
module ueb_ctrl import ueb_pkg::*; (
  input wire logic ref_clk_i, // 20 MHz device clock
  input wire logic nrst_i, // Power-on reset, active low
  input wire logic external_reset_pin_n_i, // Chip reset pin, active low
  input wire logic usb_bus_reset_i, // USB bus reset seen by engine
  input wire logic power_down_i, // Power-down state
  input wire ueb_cpu_req_t cpu_i, // Register port request
  output logic [7:0] cpu_rdata_o, // Register read byte
  input wire ueb_sie_t sie_i, // Packet events from engine
  output ueb_hs_t hs_o, // Handshake to send
  output logic [7:0] tx_data_o, // Endpoint 0 IN byte
  output logic [6:0] tx_len_o, // Endpoint 0 IN length
  output logic [2:0] data_toggle_o, // Toggles of ep1 out, ep2, ep3
  output logic bulk_out_data_avail_o, // Endpoint 1 data waiting
  output logic connect_o // Bus-attach pull-up enable
);
  ueb_state_t r_reg, r_next;
  logic chip_rst;
  logic quiet;
  logic bulk_full, bulk_avail;
  logic [6:0] bulk_cnt;
  logic [7:0] bulk_byte;
  logic cpu_rd, cpu_wr;
  logic bulk_start, bulk_wr, bulk_commit, bulk_pop, bulk_release;

  // Pointer step that stops at the buffer end
  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    ptr_inc = (p < `UEB_BUF_BYTES) ? 7'(p + `UEB_PTR_STEP) : p;
  endfunction

  // Buffer and count registers are blocked in power-down
  function automatic logic blocked(input logic [4:0] a, input logic pd);
    blocked = pd && (a == `UEB_R_EP0BUF || a == `UEB_R_EP1BUF ||
                     a == `UEB_R_CTRL_EP_BYTE_COUNT || a == `UEB_R_EP1BC);
  endfunction

  assign chip_rst = !external_reset_pin_n_i || r_reg.chipres;
  assign quiet = !chip_rst && !usb_bus_reset_i;
  assign cpu_rd = cpu_i.byte_stb && !cpu_i.start && !r_reg.wr && !blocked(r_reg.addr, power_down_i);
  assign cpu_wr = cpu_i.byte_stb && !cpu_i.start && r_reg.wr && !blocked(r_reg.addr, power_down_i);

  // Strobes to the bulk OUT banks
  assign bulk_start = r_reg.phase == UEB_IDLE && sie_i.tok_out && sie_i.ep == `UEB_EP_BULK &&
                      !r_reg.dis1 && !bulk_full;
  assign bulk_wr = r_reg.phase == UEB_RX_BULK && sie_i.rx_stb;
  assign bulk_commit = r_reg.phase == UEB_RX_BULK && sie_i.pkt_ok && !sie_i.pkt_err; // [RULE16]
  assign bulk_pop = cpu_rd && r_reg.addr == `UEB_R_EP1BUF;
  assign bulk_release = cpu_wr && r_reg.addr == `UEB_R_EPIRQ && cpu_i.wdata[`UEB_B_IRQ_OUT1];

  ueb_dbuf u_dbuf (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_i(chip_rst),
    .bus_rst_i(usb_bus_reset_i),
    .start_i(bulk_start),
    .wr_i(bulk_wr),
    .wdata_i(sie_i.rx_data),
    .commit_i(bulk_commit),
    .pop_i(bulk_pop),
    .release_i(bulk_release),
    .full_o(bulk_full),
    .avail_o(bulk_avail),
    .count_o(bulk_cnt),
    .rdata_o(bulk_byte)
  );

  // Output drive
  assign cpu_rdata_o = r_reg.rdata;
  assign hs_o = r_reg.hs;
  assign tx_data_o = r_reg.tx_data;
  assign tx_len_o = r_reg.ep0_bc;
  assign data_toggle_o = r_reg.tog;
  assign bulk_out_data_avail_o = bulk_avail;
  assign connect_o = r_reg.connect;

  // Read value of a control register
  function automatic logic [7:0] ctl_read(input ueb_state_t s, input logic [6:0] bc1,
                                          input logic av1, input logic [4:0] a);
    logic [7:0] v;
    v = `UEB_BYTE_ZERO;
    case (a)
      `UEB_R_CTRL_EP_BYTE_COUNT: v = {1'b0, s.ep0_bc}; // [RULE9]
      `UEB_R_EP1BC: v = {1'b0, bc1}; // [RULE9]
      `UEB_R_TOGDIS: begin
        v[`UEB_B_CTG_HI:`UEB_B_CTG_LO] = s.ctg;
        v[`UEB_B_DIS1] = s.dis1;
      end
      `UEB_R_EPIRQ: begin
        v[`UEB_B_IRQ_OUT0] = s.ep0_dav;
        v[`UEB_B_IRQ_OUT1] = av1;
      end
      `UEB_R_USBCTL: begin
        v[`UEB_B_CONNECT] = s.connect;
        v[`UEB_B_CHIPRES] = s.chipres;
      end
      `UEB_R_PIN_CONTROL_REG: v[`UEB_B_NAK0] = s.nak0;
      default: v = `UEB_BYTE_ZERO;
    endcase
    ctl_read = v;
  endfunction

  // Next state: register port, then USB traffic, then resets
  always_comb begin
    r_next = r_reg;
    r_next.hs.valid = 1'b0;
    r_next.ctg = 3'b000; // Pending clears are served this cycle
    // Register port
    if (cpu_i.start) begin
      r_next.addr = cpu_i.addr;
      r_next.wr = cpu_i.wr;
    end else if (cpu_i.byte_stb) begin
      if (r_reg.addr >= `UEB_R_FIRST_CTL && r_reg.addr < `UEB_R_LAST) begin
        r_next.addr = 5'(r_reg.addr + 5'h01); // [RULE23]
      end
      if (cpu_rd) begin
        case (r_reg.addr)
          `UEB_R_EP0BUF: begin
            r_next.rdata = r_reg.ep0_mem[r_reg.ep0_cptr[5:0]]; // [RULE23]
            r_next.ep0_cptr = ptr_inc(r_reg.ep0_cptr);
          end
          `UEB_R_EP1BUF: r_next.rdata = bulk_byte; // [RULE23]
          default: r_next.rdata = ctl_read(r_reg, bulk_cnt, bulk_avail, r_reg.addr);
        endcase
      end else if (!r_reg.wr) begin
        r_next.rdata = `UEB_BYTE_ZERO; // [RULE22]
      end
      if (cpu_wr) begin
        case (r_reg.addr)
          `UEB_R_EP0BUF: begin
            if (r_reg.ep0_cptr < `UEB_BUF_BYTES) begin
              r_next.ep0_mem[r_reg.ep0_cptr[5:0]] = cpu_i.wdata; // [RULE10]
            end
            r_next.ep0_cptr = ptr_inc(r_reg.ep0_cptr);
          end
          `UEB_R_CTRL_EP_BYTE_COUNT: begin
            r_next.ep0_bc = cpu_i.wdata[6:0]; // [RULE9]
            r_next.ep0_armed = 1'b1; // [RULE7]
            r_next.ep0_cptr = 7'h00;
          end
          `UEB_R_TOGDIS: begin
            r_next.ctg = cpu_i.wdata[`UEB_B_CTG_HI:`UEB_B_CTG_LO]; // [RULE2] [RULE3] [RULE4]
            r_next.dis1 = cpu_i.wdata[`UEB_B_DIS1]; // [RULE14]
          end
          `UEB_R_EPIRQ: begin
            if (cpu_i.wdata[`UEB_B_IRQ_OUT0]) begin
              r_next.ep0_dav = 1'b0;
            end
          end
          `UEB_R_USBCTL: begin
            r_next.connect = cpu_i.wdata[`UEB_B_CONNECT];
            r_next.chipres = cpu_i.wdata[`UEB_B_CHIPRES];
          end
          `UEB_R_PIN_CONTROL_REG: begin
            if (cpu_i.wdata[`UEB_B_NAK0]) begin
              r_next.nak0 = 1'b0;
            end
          end
          default: r_next.rdata = r_reg.rdata;
        endcase
      end
    end
    // USB transaction sequencing
    case (r_reg.phase)
      UEB_IDLE: begin
        if (sie_i.tok_out && sie_i.ep == `UEB_EP_CTRL) begin
          r_next.phase = UEB_RX_CTRL; // [RULE15]
          r_next.ep0_uptr = 7'h00;
        end else if (sie_i.tok_out && sie_i.ep == `UEB_EP_BULK && !r_reg.dis1) begin
          r_next.phase = bulk_full ? UEB_RX_DROP : UEB_RX_BULK; // [RULE20]
        end else if (sie_i.tok_in && sie_i.ep == `UEB_EP_CTRL) begin
          r_next.hs.valid = 1'b1;
          if (r_reg.ep0_armed) begin
            r_next.hs.code = UEB_HS_DATA; // [RULE7]
            r_next.phase = UEB_TX_CTRL;
            r_next.ep0_uptr = 7'h00;
          end else begin
            r_next.hs.code = UEB_HS_NAK;
            r_next.nak0 = 1'b1; // [RULE13]
          end
        end else if (sie_i.host_ack && sie_i.ep == `UEB_EP_IN2) begin
          r_next.tog[1] = ~r_reg.tog[1];
        end else if (sie_i.host_ack && sie_i.ep == `UEB_EP_IN3) begin
          r_next.tog[2] = ~r_reg.tog[2];
        end
      end
      UEB_RX_CTRL: begin
        if (sie_i.rx_stb) begin
          if (r_reg.ep0_uptr < `UEB_BUF_BYTES) begin
            r_next.ep0_mem[r_reg.ep0_uptr[5:0]] = sie_i.rx_data; // [RULE10]
          end
          r_next.ep0_uptr = ptr_inc(r_reg.ep0_uptr);
        end
        if (sie_i.pkt_err) begin
          r_next.phase = UEB_IDLE; // [RULE12]
        end else if (sie_i.pkt_ok) begin
          r_next.phase = UEB_IDLE;
          r_next.ep0_bc = r_reg.ep0_uptr; // [RULE8]
          r_next.ep0_dav = 1'b1;
          r_next.ep0_cptr = 7'h00;
          r_next.hs.valid = 1'b1;
          r_next.hs.code = UEB_HS_ACK;
        end
      end
      UEB_RX_BULK: begin
        if (sie_i.pkt_err) begin
          r_next.phase = UEB_IDLE; // [RULE12]
        end else if (sie_i.pkt_ok) begin
          r_next.phase = UEB_IDLE;
          r_next.tog[0] = ~r_reg.tog[0];
          r_next.hs.valid = 1'b1; // [RULE16] [RULE19]
          r_next.hs.code = UEB_HS_ACK;
        end
      end
      UEB_RX_DROP: begin
        if (sie_i.pkt_err) begin
          r_next.phase = UEB_IDLE;
        end else if (sie_i.pkt_ok) begin
          r_next.phase = UEB_IDLE;
          r_next.hs.valid = 1'b1; // [RULE20]
          r_next.hs.code = UEB_HS_NAK;
        end
      end
      UEB_TX_CTRL: begin
        if (sie_i.tx_stb) begin
          r_next.tx_data = r_reg.ep0_mem[r_reg.ep0_uptr[5:0]];
          r_next.ep0_uptr = ptr_inc(r_reg.ep0_uptr);
        end
        if (sie_i.host_ack) begin
          r_next.ep0_armed = 1'b0;
          r_next.phase = UEB_IDLE;
        end else if (sie_i.pkt_err) begin
          r_next.phase = UEB_IDLE; // [RULE12]
        end
      end
      default: r_next.phase = UEB_IDLE;
    endcase
    // Served toggle clears win over toggle flips
    r_next.tog = r_next.tog & ~r_reg.ctg; // [RULE2] [RULE3] [RULE4] [RULE24]
    // USB bus reset keeps buffer contents
    if (usb_bus_reset_i) begin
      r_next.phase = UEB_IDLE;
      r_next.tog = 3'b000; // [RULE5]
      r_next.ctg = 3'b000;
      r_next.ep0_bc = 7'h00;
      r_next.ep0_armed = 1'b0;
      r_next.ep0_dav = 1'b0;
      r_next.nak0 = 1'b0;
      r_next.dis1 = 1'b0;
      r_next.hs.valid = 1'b0;
    end
    // Chip reset clears all but the attach and reset bits
    if (chip_rst) begin
      r_next = '0; // [RULE5] [RULE22]
      r_next.connect = r_reg.connect; // [RULE1]
      r_next.chipres = r_next.chipres | r_reg.chipres;
      if (cpu_wr && r_reg.addr == `UEB_R_USBCTL) begin
        r_next.connect = cpu_i.wdata[`UEB_B_CONNECT];
        r_next.chipres = cpu_i.wdata[`UEB_B_CHIPRES];
      end
    end
  end

  // State register; only power-on reset reaches the attach bit
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0; // [RULE1]
    end else begin
      r_reg <= r_next;
    end
  end

  connect_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
    (!external_reset_pin_n_i && !(cpu_wr && r_reg.addr == `UEB_R_USBCTL))
      |=> r_reg.connect == $past(r_reg.connect))
    else $error("attach bit changed by chip reset");
  tog1_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE2]
    (cpu_wr && r_reg.addr == `UEB_R_TOGDIS && cpu_i.wdata[`UEB_B_CTG_LO] && quiet)
      |=> r_reg.ctg[0] ##1 !r_reg.tog[0])
    else $error("endpoint 1 toggle not cleared");
  tog2_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE3]
    (r_reg.ctg[1]) |=> !r_reg.tog[1])
    else $error("endpoint 2 toggle not cleared");
  tog3_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE4]
    (r_reg.ctg[2]) |=> !r_reg.tog[2])
    else $error("endpoint 3 toggle not cleared");
  ctg_selfclr_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE24]
    (r_reg.ctg != 3'b000 && !(cpu_wr && r_reg.addr == `UEB_R_TOGDIS)) |=> r_reg.ctg == 3'b000)
    else $error("toggle-clear bit did not self-clear");
  busrst_tog_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE5]
    (usb_bus_reset_i || chip_rst) |=> r_reg.tog == 3'b000)
    else $error("toggles not reset");
  ep0_arm_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE7]
    (r_reg.phase == UEB_IDLE && sie_i.tok_in && !sie_i.tok_out && sie_i.ep == `UEB_EP_CTRL &&
     r_reg.ep0_armed && quiet) |=> r_reg.hs.valid && r_reg.hs.code == UEB_HS_DATA)
    else $error("armed endpoint 0 did not send data");
  ep0_out_ok_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE8]
    (r_reg.phase == UEB_RX_CTRL && sie_i.pkt_ok && !sie_i.pkt_err && quiet)
      |=> r_reg.ep0_dav && r_reg.ep0_bc == $past(r_reg.ep0_uptr) && r_reg.hs.code == UEB_HS_ACK)
    else $error("endpoint 0 OUT completion wrong");
  bc_bit7_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE9]
    (cpu_rd && (r_reg.addr == `UEB_R_CTRL_EP_BYTE_COUNT || r_reg.addr == `UEB_R_EP1BC)) |=> !r_reg.rdata[7])
    else $error("byte count bit 7 not zero");
  err_silent_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE12]
    (r_reg.phase != UEB_IDLE && sie_i.pkt_err && !cpu_wr && quiet)
      |=> $stable(r_reg.ep0_bc) && $stable(r_reg.ep0_dav) && !r_reg.hs.valid)
    else $error("faulty packet changed state");
  nak_flag_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE13]
    (r_reg.phase == UEB_IDLE && sie_i.tok_in && !sie_i.tok_out && sie_i.ep == `UEB_EP_CTRL &&
     !r_reg.ep0_armed && quiet) |=> r_reg.nak0 && r_reg.hs.code == UEB_HS_NAK)
    else $error("endpoint 0 IN NAK not flagged");
  ep1_off_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE14]
    (r_reg.phase == UEB_IDLE && sie_i.tok_out && sie_i.ep == `UEB_EP_BULK && r_reg.dis1)
      |=> r_reg.phase == UEB_IDLE && !r_reg.hs.valid)
    else $error("disabled endpoint 1 responded");
  ep1_drop_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE20]
    (r_reg.phase == UEB_IDLE && sie_i.tok_out && sie_i.ep == `UEB_EP_BULK && !r_reg.dis1 &&
     bulk_full && quiet) |=> r_reg.phase == UEB_RX_DROP)
    else $error("full endpoint 1 did not drop packet");
endmodule

/* hw/ueb_dbuf.sv */
// Two-bank receive buffer for the bulk OUT endpoint
`timescale 1ns/1ps
`include "ueb_consts.svh"
module ueb_dbuf import ueb_pkg::*; (
  input wire logic ref_clk_i, // Device clock
  input wire logic nrst_i, // Power-on reset, active low
  input wire logic clr_i, // Chip reset, zeroes data
  input wire logic bus_rst_i, // Bus reset, keeps data
  input wire logic start_i, // Packet accepted, restart fill
  input wire logic wr_i, // Received byte strobe
  input wire logic [7:0] wdata_i, // Received byte
  input wire logic commit_i, // Good packet end
  input wire logic pop_i, // CPU reads one byte
  input wire logic release_i, // CPU frees drained bank
  output logic full_o, // Both banks hold data
  output logic avail_o, // Data-available flag
  output logic [6:0] count_o, // Byte count of drain bank
  output logic [7:0] rdata_o // Byte at read pointer
);
  ueb_dbuf_t r_reg, r_next;

  // Outputs other than full_o look at the bank the CPU drains
  assign full_o = &r_reg.full;
  assign avail_o = r_reg.full[r_reg.drain];
  assign count_o = avail_o ? r_reg.cnt[r_reg.drain] : 7'h00;
  assign rdata_o = avail_o ? r_reg.mem[r_reg.drain][r_reg.rptr[5:0]] : `UEB_BYTE_ZERO;

  // Bank fill, commit and release
  always_comb begin
    r_next = r_reg;
    if (start_i) begin
      r_next.wptr = 7'h00;
    end
    if (wr_i && r_reg.wptr < `UEB_BUF_BYTES) begin
      r_next.mem[r_reg.fill][r_reg.wptr[5:0]] = wdata_i; // [RULE17]
      r_next.wptr = 7'(r_reg.wptr + `UEB_PTR_STEP);
    end
    if (pop_i && avail_o && r_reg.rptr < `UEB_BUF_BYTES) begin
      r_next.rptr = 7'(r_reg.rptr + `UEB_PTR_STEP);
    end
    if (release_i && avail_o) begin
      r_next.full[r_reg.drain] = 1'b0;
      r_next.drain = ~r_reg.drain;
      r_next.rptr = 7'h00;
    end
    // Commit after release so a new packet is never lost
    if (commit_i && !r_reg.full[r_reg.fill]) begin
      r_next.full[r_reg.fill] = 1'b1; // [RULE18] [RULE19]
      r_next.cnt[r_reg.fill] = r_reg.wptr;
      r_next.fill = ~r_reg.fill;
    end
    if (bus_rst_i) begin
      r_next.full = 2'b00;
      r_next.cnt = '0;
      r_next.fill = 1'b0;
      r_next.drain = 1'b0;
      r_next.wptr = 7'h00;
      r_next.rptr = 7'h00;
    end
    if (clr_i) begin
      r_next = '0; // [RULE22]
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  first_avail_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE18]
    (r_reg.full == 2'b00 && commit_i && !clr_i && !bus_rst_i) |=> avail_o && !full_o)
    else $error("first packet did not raise data-available");
  second_bank_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE19]
    ($onehot(r_reg.full) && commit_i && !release_i && !clr_i && !bus_rst_i) |=> full_o)
    else $error("second packet not stored in free bank");
endmodule

/* hw/ueb_pkg.sv */
// Types shared by the endpoint buffer control block
package ueb_pkg;
  typedef enum logic [1:0] {UEB_HS_ACK, UEB_HS_NAK, UEB_HS_DATA} ueb_hs_code_t;
  typedef enum logic [2:0] {UEB_IDLE, UEB_RX_CTRL, UEB_RX_BULK, UEB_RX_DROP, UEB_TX_CTRL} ueb_phase_t;
  typedef struct packed {
    logic start;
    logic wr;
    logic [4:0] addr;
    logic byte_stb;
    logic [7:0] wdata;
  } ueb_cpu_req_t;
  typedef struct packed {
    logic tok_out;
    logic tok_in;
    logic [1:0] ep;
    logic rx_stb;
    logic [7:0] rx_data;
    logic pkt_ok;
    logic pkt_err;
    logic tx_stb;
    logic host_ack;
  } ueb_sie_t;
  typedef struct packed {
    logic valid;
    ueb_hs_code_t code;
  } ueb_hs_t;
  typedef struct packed {
    ueb_phase_t phase;
    logic [4:0] addr;
    logic wr;
    logic [7:0] rdata;
    logic [63:0][7:0] ep0_mem;
    logic [6:0] ep0_bc;
    logic [6:0] ep0_uptr;
    logic [6:0] ep0_cptr;
    logic ep0_armed;
    logic ep0_dav;
    logic nak0;
    logic [2:0] ctg;
    logic dis1;
    logic [2:0] tog;
    logic connect;
    logic chipres;
    ueb_hs_t hs;
    logic [7:0] tx_data;
  } ueb_state_t;
  typedef struct packed {
    logic [1:0][63:0][7:0] mem;
    logic [1:0][6:0] cnt;
    logic [1:0] full;
    logic fill;
    logic drain;
    logic [6:0] wptr;
    logic [6:0] rptr;
  } ueb_dbuf_t;
endpackage
